//--- design/msp_top.sv
// Multi-mode serial port: synchronous shift and UART core, Avalon slave
`timescale 1ns/1ps
module msp_top #(
  parameter int BAUD_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_clock_pin_in,
  input wire logic data_io_pin_in,
  output msp_pkg::msp_pins_t pins,
  output logic psw_stop_bit,
  output logic irq
);
  import msp_pkg::*;

  logic rst_s1, rst_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  logic rn;
  assign rn = rst_s2;

  // Pin synchronisers; stage one is read only by stage two
  logic sck_s1, sck_s2, sck_d, dio_s1, dio_s2, dio_d;
  always_ff @(posedge clk or negedge rn) begin
    if (!rn) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_d <= 1'b1;
      dio_s1 <= 1'b1;
      dio_s2 <= 1'b1;
      dio_d <= 1'b1;
    end else begin
      sck_s1 <= serial_clock_pin_in;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      dio_s1 <= data_io_pin_in;
      dio_s2 <= dio_s1;
      dio_d <= dio_s2;
    end
  end

  logic [8:0] ctrl;
  logic [8:0] sbuf;
  logic [BAUD_W-1:0] baud;
  logic [MSP_IRQ_W-1:0] irq_stat, irq_en;
  logic [7:0] shifter;
  logic [3:0] bitcnt;
  logic phase;
  logic clk_lvl;
  logic [8:0] next_sbuf;

  msp_mode_t mode;
  assign mode = msp_mode_t'({ctrl[MSP_CTRL_MODE_HI], ctrl[MSP_CTRL_MODE_LO]});
  logic is_sync, is_uart, extclk, run, endf, rec, lsb_first;
  assign is_sync = (mode == MSP_MODE_SYNC);
  assign is_uart = (mode == MSP_MODE_UART);
  assign extclk = ctrl[MSP_CTRL_EXTCLK] && is_sync;
  assign run = ctrl[MSP_CTRL_RUN];
  assign endf = ctrl[MSP_CTRL_END];
  assign rec = ctrl[MSP_CTRL_REC];
  assign lsb_first = ctrl[MSP_CTRL_ORDER];

  // Bus decode; zero wait states
  logic wr_ctrl, wr_buf, wr_baud, wr_ien, wr_iclr, rd_buf;
  assign avs_waitrequest = 1'b0;
  assign wr_ctrl = avs_write && (avs_address == MSP_CTRL_OFS);
  assign wr_buf = avs_write && (avs_address == MSP_BUF_OFS);
  assign wr_baud = avs_write && (avs_address == MSP_BAUD_OFS);
  assign wr_ien = avs_write && (avs_address == MSP_IRQ_EN_OFS);
  assign wr_iclr = avs_write && (avs_address == MSP_IRQ_CLR_OFS);
  assign rd_buf = avs_read && (avs_address == MSP_BUF_OFS);

  // Internal clock half-bit ticks; a UART bit spans two ticks
  logic tick;
  msp_tick #(.W(BAUD_W)) u_baud (
    .clk(clk),
    .rst_n(rn),
    .run(run && !extclk),
    .reload(baud),
    .tick(tick)
  );

  // Sync clock edges: own divider or external pin
  logic int_fall, int_rise, ext_fall, ext_rise, s_fall, s_rise;
  assign int_fall = tick && !phase && is_sync && !extclk;
  assign int_rise = tick && phase && is_sync && !extclk;
  assign ext_fall = !sck_s2 && sck_d;
  assign ext_rise = sck_s2 && !sck_d;
  assign s_fall = extclk ? ext_fall && run : int_fall;
  assign s_rise = extclk ? ext_rise && run : int_rise;

  // UART: start on falling data edge; mid-bit sample on the first
  // half-bit tick, bit boundary on the second
  logic dio_fall, u_start, u_mid, u_tick, u_sample_data, u_stop;
  assign dio_fall = !dio_s2 && dio_d;
  assign u_start = is_uart && !run && !endf && dio_fall;
  assign u_mid = is_uart && run && tick && !phase;
  assign u_tick = is_uart && run && tick && phase;

  // Input is held from mid-bit and shifted in at the boundary, so the
  // shifter keeps each outgoing bit on the pin for a whole bit time
  logic rx_mid;
  always_ff @(posedge clk or negedge rn) begin
    if (!rn) begin
      rx_mid <= 1'b1;
    end else if (u_mid) begin
      rx_mid <= dio_s2;
    end
  end
  logic in_bit;
  assign in_bit = is_uart ? rx_mid : dio_s2;
  assign u_sample_data = u_tick && (bitcnt >= 4'd1) && (bitcnt <= 4'd8);
  assign u_stop = u_tick && (bitcnt == 4'(MSP_UART_BITS));

  logic s_done, done;
  assign s_done = is_sync && s_rise &&
                  (bitcnt == 4'(MSP_SYNC_BITS - 1));
  assign done = s_done || u_stop;

  // Serial output bit, chosen by bit order
  logic out_bit;
  assign out_bit = lsb_first ? shifter[0] : shifter[7];

  logic [7:0] shift_in;
  assign shift_in = lsb_first ? {in_bit, shifter[7:1]} :
                                {shifter[6:0], in_bit};

  logic start_run, start_sync;
  assign start_sync = wr_ctrl && avs_writedata[MSP_CTRL_RUN] && !run;
  assign start_run = start_sync || u_start;

  logic idle_edge_ovr, ovr_set;
  assign idle_edge_ovr = !run && !is_uart ? ext_fall && extclk :
                         (is_uart && !run && ext_fall);
  assign ovr_set = (done && endf) || idle_edge_ovr;

  always_ff @(posedge clk or negedge rn) begin
    if (!rn) begin
      shifter <= 8'hFF;
      bitcnt <= 4'h0;
      phase <= 1'b0;
      clk_lvl <= 1'b1;
    end else if (start_run) begin
      shifter <= sbuf[7:0];
      bitcnt <= 4'h0;
      phase <= 1'b0;
      clk_lvl <= 1'b1;
    end else if (run) begin
      if (tick) begin
        phase <= !phase;
      end
      if (s_fall) begin
        clk_lvl <= 1'b0;
      end
      if (s_rise) begin
        clk_lvl <= 1'b1;
        shifter <= shift_in;
        bitcnt <= bitcnt + 4'h1;
      end
      if (u_tick) begin
        bitcnt <= bitcnt + 4'h1;
        if (u_sample_data) begin
          shifter <= shift_in;
        end
      end
    end
  end

  // Buffer bits 0-7 take the shifter at completion, bit 8 on stop
  always_comb begin
    next_sbuf = sbuf;
    if (wr_buf) begin
      next_sbuf = avs_writedata[8:0];
    end
    if (s_done) begin
      next_sbuf[7:0] = shift_in;
    end
    if (u_stop) begin
      next_sbuf[7:0] = shifter;
      next_sbuf[8] = rx_mid;
    end
  end

  logic [8:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = avs_writedata[8:0];
    end
    if (u_start) begin
      next_ctrl[MSP_CTRL_RUN] = 1'b1;
    end
    if (done) begin
      next_ctrl[MSP_CTRL_RUN] = 1'b0;
      next_ctrl[MSP_CTRL_END] = 1'b1;
    end
    if (ovr_set) begin
      next_ctrl[MSP_CTRL_OVR] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rn) begin
    if (!rn) begin
      ctrl <= MSP_CTRL_RST;
      sbuf <= MSP_BUF_RST;
      baud <= BAUD_W'(MSP_BAUD_RST);
      psw_stop_bit <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      sbuf <= next_sbuf;
      if (wr_baud) begin
        baud <= avs_writedata[BAUD_W-1:0];
      end
      if (rd_buf && is_uart) begin
        psw_stop_bit <= sbuf[8];
      end
    end
  end

  // Interrupt status: set wins over clear
  logic [MSP_IRQ_W-1:0] irq_ev;
  assign irq_ev = {ovr_set, done};
  always_ff @(posedge clk or negedge rn) begin
    if (!rn) begin
      irq_stat <= '0;
      irq_en <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_iclr ? avs_writedata[MSP_IRQ_W-1:0] :
                   '0)) | irq_ev;
      if (wr_ien) begin
        irq_en <= avs_writedata[MSP_IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_en) && ctrl[MSP_CTRL_IE];

  // Read mux over register outputs; data stands while read is held
  logic [31:0] rd_mux;
  assign rd_mux =
    (avs_address == MSP_CTRL_OFS) ? {23'h0, ctrl} :
    (avs_address == MSP_BUF_OFS) ? {23'h0, sbuf} :
    (avs_address == MSP_BAUD_OFS) ? 32'(baud) :
    (avs_address == MSP_STAT_OFS) ? {31'h0, psw_stop_bit} :
    (avs_address == MSP_IRQ_STAT_OFS) ? {30'h0, irq_stat} :
    (avs_address == MSP_IRQ_EN_OFS) ? {30'h0, irq_en} : 32'h0;
  always_comb begin
    avs_readdata = avs_read ? rd_mux : 32'h0;
  end

  // UART output frame: start low, data, stop high
  logic u_out;
  assign u_out = (bitcnt == 4'h0) ? 1'b0 :
                 (bitcnt <= 4'd8) ? out_bit : 1'b1;
  logic tx_bit;
  assign tx_bit = !run ? 1'b1 : rec ? 1'b1 :
                  is_uart ? u_out : out_bit;
  always_comb begin
    pins.clk_out = clk_lvl;
    pins.clk_oe = is_sync && !extclk;
    pins.dout = tx_bit;
    pins.dio_out = 1'b0;
    pins.dio_oe = run && !rec && !tx_bit;
  end

  a_done_sets_end: assert property (@(posedge clk) disable iff (!rn)
    done |=> endf) else $error("end flag not set");
  a_ovr_on_double: assert property (@(posedge clk) disable iff (!rn)
    (done && endf) |=> ctrl[MSP_CTRL_OVR])
    else $error("overrun missed");
  a_uart_autostart: assert property (@(posedge clk) disable iff (!rn)
    u_start |=> run) else $error("uart start missed");
  a_stop_bit8: assert property (@(posedge clk) disable iff (!rn)
    u_stop |=> sbuf[8] == $past(rx_mid))
    else $error("bit 8 wrong");
  a_sync_no_bit8: assert property (@(posedge clk) disable iff (!rn)
    (is_sync && !wr_buf) |=> $stable(sbuf[8]))
    else $error("bit 8 moved");
  a_psw_copy: assert property (@(posedge clk) disable iff (!rn)
    (rd_buf && is_uart) |=> psw_stop_bit == $past(sbuf[8]))
    else $error("psw copy wrong");
  a_load_shift: assert property (@(posedge clk) disable iff (!rn)
    start_run |=> shifter == $past(sbuf[7:0]))
    else $error("shifter load");
  a_clk_drive: assert property (@(posedge clk) disable iff (!rn)
    pins.clk_oe == (is_sync && !extclk))
    else $error("clock dir");
  a_mode_sync: assert property (@(posedge clk) disable iff (!rn)
    (is_sync && run && !rec) |-> pins.dout == out_bit)
    else $error("sync framing");
endmodule

//--- design/msp_pkg.sv
// Package of constants and types for the multi-mode serial port
package msp_pkg;
  localparam logic [3:0] MSP_CTRL_OFS = 4'h0;
  localparam logic [3:0] MSP_BUF_OFS = 4'h1;
  localparam logic [3:0] MSP_BAUD_OFS = 4'h2;
  localparam logic [3:0] MSP_STAT_OFS = 4'h3;
  localparam logic [3:0] MSP_IRQ_STAT_OFS = 4'h4;
  localparam logic [3:0] MSP_IRQ_EN_OFS = 4'h5;
  localparam logic [3:0] MSP_IRQ_CLR_OFS = 4'h6;
  localparam int MSP_CTRL_MODE_LO = 0;
  localparam int MSP_CTRL_MODE_HI = 1;
  localparam int MSP_CTRL_ORDER = 2;
  localparam int MSP_CTRL_IE = 3;
  localparam int MSP_CTRL_REC = 4;
  localparam int MSP_CTRL_RUN = 5;
  localparam int MSP_CTRL_END = 6;
  localparam int MSP_CTRL_OVR = 7;
  localparam int MSP_CTRL_EXTCLK = 8;
  localparam logic [8:0] MSP_CTRL_RST = 9'h000;
  localparam logic [8:0] MSP_BUF_RST = 9'h1FF;
  localparam logic [7:0] MSP_BAUD_RST = 8'h00;
  localparam int MSP_STAT_PSW1 = 0;
  localparam int MSP_IRQ_END = 0;
  localparam int MSP_IRQ_OVR = 1;
  localparam int MSP_IRQ_W = 2;
  localparam int MSP_SYNC_BITS = 8;
  localparam int MSP_UART_BITS = 9;

  typedef enum logic [1:0] {
    MSP_MODE_SYNC,
    MSP_MODE_UART,
    MSP_MODE_BMASTER,
    MSP_MODE_BSLAVE
  } msp_mode_t;

  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic dout;
    logic dio_out;
    logic dio_oe;
  } msp_pins_t;
endpackage

//--- design/msp_tick.sv
// Baud divider producing one-cycle half-bit ticks
`timescale 1ns/1ps
module msp_tick #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] reload,
  output logic tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic hit;

  assign hit = (cnt == '0);
  assign next_cnt = (!run || hit) ? reload : cnt - 1'b1;
  assign tick = run && hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

//--- test/msp_peer.sv
// Serial peer model on the clock and data pins
`timescale 1ns/1ps
module msp_peer (
  input wire logic clk,
  input wire msp_pkg::msp_pins_t pins,
  output logic sclk_line,
  output logic dio_line
);
  import msp_pkg::*;
  logic peer_clk = 1'b1;
  logic peer_dio = 1'b1;
  // Device owns the clock pin only while enabled
  assign sclk_line = pins.clk_oe ? pins.clk_out : peer_clk;
  // Data io line has a pull-up, so either party can pull it low
  assign dio_line = peer_dio & ~(pins.dio_oe & ~pins.dio_out);

  task automatic sync_xfer(input logic [7:0] tx, output logic [7:0] rx);
    // Device moves its output on the rising edge, so read it while low
    for (int i = 0; i < 8; i++) begin
      @(negedge sclk_line);
      rx[i] = pins.dout;
      peer_dio <= tx[i];
    end
    @(posedge sclk_line);
    // Hold past the synchronisers, then let the pull-up win
    repeat (4) @(posedge clk);
    peer_dio <= 1'b1;
  endtask

  // Peer owns the clock, msb first; data changes while the clock is low
  task automatic ext_xfer(input logic [7:0] tx, output logic [7:0] rx);
    repeat (4) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      peer_clk <= 1'b0;
      peer_dio <= tx[i];
      repeat (8) @(posedge clk);
      rx[i] = pins.dout;
      peer_clk <= 1'b1;
      repeat (8) @(posedge clk);
    end
    peer_dio <= 1'b1;
  endtask

  // Reads one frame off the open-drain data line at mid-bit
  task automatic uart_recv(input int cyc, output logic [7:0] rx,
                           output logic stop);
    @(negedge dio_line);
    repeat (cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(posedge clk);
      rx[i] = dio_line;
    end
    repeat (cyc) @(posedge clk);
    stop = dio_line;
  endtask

  task automatic clk_pulse;
    peer_clk <= 1'b0;
    repeat (8) @(posedge clk);
    peer_clk <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic uart_send(input logic [7:0] tx, input logic stop,
                           input int cyc);
    logic [10:0] frame;
    // Second stop bit is always high
    frame = {1'b1, stop, tx, 1'b0};
    for (int i = 0; i < 11; i++) begin
      peer_dio <= frame[i];
      repeat (cyc) @(posedge clk);
    end
  endtask
endmodule

//--- test/testbench.sv
// Self-checking testbench for the multi-mode serial port
`timescale 1ns/1ps
module testbench;
  import msp_pkg::*;
  logic clk;
  logic rst_n;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sclk_line;
  logic dio_line;
  msp_pins_t pins;
  logic psw_stop_bit;
  logic irq;
  logic [31:0] rd;
  logic [7:0] got;
  logic stopb;
  int num_errors = 0;
  int tests_run = 0;

  msp_top #(.BAUD_W(8)) u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .serial_clock_pin_in(sclk_line),
    .data_io_pin_in(dio_line),
    .pins(pins),
    .psw_stop_bit(psw_stop_bit),
    .irq(irq)
  );

  msp_peer u_peer (
    .clk(clk),
    .pins(pins),
    .sclk_line(sclk_line),
    .dio_line(dio_line)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wait_end;
    logic [31:0] q;
    q = 32'h0;
    for (int n = 0; n < 400 && q[MSP_CTRL_END] !== 1'b1; n++) begin
      bus(1'b0, MSP_CTRL_OFS, 32'h0, q);
    end
    chk({31'h0, q[MSP_CTRL_END]}, 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(MSP_CTRL_OFS, 32'(MSP_CTRL_RST));
    rdchk(MSP_BUF_OFS, 32'(MSP_BUF_RST));
    rdchk(MSP_BAUD_OFS, 32'(MSP_BAUD_RST));
    rdchk(4'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({27'h0, pins}, 32'h1C);
    // Sync, internal clock, lsb first; bit 8 must survive
    wr(MSP_BAUD_OFS, 32'h3);
    wr(MSP_IRQ_EN_OFS, 32'h3);
    wr(MSP_BUF_OFS, 32'h1A5);
    fork
      u_peer.sync_xfer(8'h3C, got);
      wr(MSP_CTRL_OFS, 32'h2C);
    join
    wait_end;
    chk({24'h0, got}, 32'hA5);
    // Wired-AND line: the peer byte meets the device's own open drain
    rdchk(MSP_BUF_OFS, 32'h124);
    chk({31'h0, irq}, 32'h1);
    // Restart with end still set
    fork
      u_peer.sync_xfer(8'h00, got);
      wr(MSP_CTRL_OFS, 32'h6C);
    join
    repeat (8) @(posedge clk);
    chk({24'h0, got}, 32'h24);
    rdchk(MSP_CTRL_OFS, 32'hCC);
    rdchk(MSP_IRQ_STAT_OFS, 32'h3);
    wr(MSP_IRQ_CLR_OFS, 32'h3);
    rdchk(MSP_IRQ_STAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // External clock edge while idle
    wr(MSP_CTRL_OFS, 32'h108);
    rdchk(MSP_CTRL_OFS, 32'h108);
    u_peer.clk_pulse;
    rdchk(MSP_CTRL_OFS, 32'h188);
    // Sync, external clock, msb first
    wr(MSP_BUF_OFS, 32'hE1);
    fork
      u_peer.ext_xfer(8'h5C, got);
      wr(MSP_CTRL_OFS, 32'h128);
    join
    wait_end;
    chk({24'h0, got}, 32'hE1);
    rdchk(MSP_BUF_OFS, 32'h040);
    rdchk(MSP_CTRL_OFS, 32'h148);
    // UART receive, stop bit high then low
    wr(MSP_CTRL_OFS, 32'h1D);
    u_peer.uart_send(8'h5A, 1'b1, 8);
    wait_end;
    rdchk(MSP_BUF_OFS, 32'h15A);
    @(negedge clk);
    chk({31'h0, psw_stop_bit}, 32'h1);
    rdchk(MSP_STAT_OFS, 32'h1);
    wr(MSP_CTRL_OFS, 32'h1D);
    u_peer.uart_send(8'hC3, 1'b0, 8);
    wait_end;
    rdchk(MSP_BUF_OFS, 32'h0C3);
    @(negedge clk);
    chk({31'h0, psw_stop_bit}, 32'h0);
    rdchk(MSP_STAT_OFS, 32'h0);
    // UART transmit through the open-drain data pin
    wr(MSP_BUF_OFS, 32'h04B);
    fork
      u_peer.uart_recv(8, got, stopb);
      wr(MSP_CTRL_OFS, 32'h2D);
    join
    wait_end;
    chk({24'h0, got}, 32'h4B);
    chk({31'h0, stopb}, 32'h1);
    rdchk(MSP_BUF_OFS, 32'h14B);
    tally_and_finish;
  end
endmodule
